//--- design/ias_pkg.sv
package ias_pkg;
    localparam int NSRC = 15;
    localparam int NSHR = 6;
    localparam int ACC_CYCLES = 8;
    // Source indices, highest priority first.
    localparam logic [3:0] SRC_UART0 = 4'h4;
    localparam logic [3:0] SRC_UART1 = 4'h5;
    localparam logic [3:0] SRC_WDTWT = 4'hD;
    // Shared source flag bit positions.
    localparam int SHR_WDT = 0;
    localparam int SHR_WT = 1;
    localparam int SHR_U0TX = 2;
    localparam int SHR_U0RX = 3;
    localparam int SHR_U1TX = 4;
    localparam int SHR_U1RX = 5;
    // Status word fields, reset values and fixed addresses.
    localparam int PSW_I_BIT = 2;
    localparam int PSW_B_BIT = 4;
    localparam logic [7:0] PSW_RST = 8'h00;
    localparam logic [7:0] SP_RST = 8'hFF;
    localparam logic [7:0] STACK_PAGE = 8'h01;
    localparam logic [15:0] VEC_BASE = 16'hFFE0;
    localparam logic [15:0] TCALL0_VEC = 16'hFFDE;
    // Register offsets.
    localparam logic [7:0] REG_ENH = 8'h00;
    localparam logic [7:0] REG_ENL = 8'h01;
    localparam logic [7:0] REG_REQH = 8'h02;
    localparam logic [7:0] REG_REQL = 8'h03;
    localparam logic [7:0] REG_SHR = 8'h04;
    localparam logic [7:0] REG_PSW = 8'h05;
    localparam logic [7:0] REG_SP = 8'h06;
    typedef enum logic [3:0] {
        S_IDLE = 4'b0000,
        S_ACC0 = 4'b0001,
        S_ACC1 = 4'b0011,
        S_ACC2 = 4'b0010,
        S_ACC3 = 4'b0110,
        S_ACC4 = 4'b0111,
        S_ACC5 = 4'b0101,
        S_ACC6 = 4'b0100,
        S_ACC7 = 4'b1100,
        S_RET0 = 4'b1101,
        S_RET1 = 4'b1111,
        S_RET2 = 4'b1110,
        S_RET3 = 4'b1010
    } ias_state_type;
endpackage : ias_pkg

//--- design/ias_sequencer.sv
// Design decisions made here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
module ias_sequencer import ias_pkg::*; #(
    parameter logic [15:0] VEC_BASE_P = VEC_BASE,
    parameter logic [15:0] TCALL0_P = TCALL0_VEC
) (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire logic [NSRC-1:0] src_event_in,
    input wire logic [NSHR-1:0] shared_event_in,
    input wire logic instr_done_in,
    input wire logic break_op_in,
    input wire logic irq_enable_op_in,
    input wire logic irq_return_op_in,
    input wire logic [15:0] ret_pc_in,
    output logic busy_out,
    output logic ack_out,
    output logic [3:0] ack_src_out,
    output logic [15:0] pc_out,
    output logic pc_load_out,
    output logic mem_wr_out,
    output logic mem_rd_out,
    output logic [15:0] mem_addr_out,
    output logic [7:0] mem_wdata_out,
    input wire logic [7:0] mem_rdata_in,
    output logic [7:0] psw_out,
    output logic [7:0] sp_out
);
    typedef struct packed {
        ias_state_type state;
        logic [15:0] en;
        logic [15:0] req;
        logic [NSHR-1:0] shr;
        logic [7:0] processor_status_word;
        logic [7:0] saved_psw;
        logic [7:0] sp;
        logic [3:0] src;
        logic break_op;
        logic brk_pend;
        logic nmi_blk;
        logic [15:0] ret_pc;
        logic [15:0] vec;
        logic mem_wr;
        logic mem_rd;
        logic [15:0] mem_addr;
        logic [7:0] mem_wdata;
        logic [15:0] pc;
        logic pc_load;
        logic ack;
        logic [7:0] rdata;
    } ias_st_type;

    ias_st_type st_r;
    ias_st_type st_nxt;
    logic [15:0] set_vec;
    logic [15:0] elig;
    logic [3:0] win;
    logic win_ok;
    logic accept_c;
    logic brk_sel;
    logic req_wr;

    // Source i maps to bit 15-i of the request and enable words.
    always_comb begin
        set_vec = '0;
        for (int i = 0; i < NSRC; i++) begin
            set_vec[15-i] = src_event_in[i];
        end
        set_vec[15-int'(SRC_WDTWT)] |= shared_event_in[SHR_WDT] |
            shared_event_in[SHR_WT];
        set_vec[15-int'(SRC_UART0)] |= shared_event_in[SHR_U0TX] |
            shared_event_in[SHR_U0RX];
        set_vec[15-int'(SRC_UART1)] |= shared_event_in[SHR_U1TX] |
            shared_event_in[SHR_U1RX];
    end

    // Fixed polling from source 0 upward picks the winner.
    always_comb begin
        elig = st_r.req & st_r.en & {16{st_r.processor_status_word[PSW_I_BIT]}};
        win = 4'h0;
        win_ok = 1'b0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (elig[15-i]) begin
                win = 4'(i);
                win_ok = 1'b1;
            end
        end
    end

    assign brk_sel = !win_ok && st_r.brk_pend;
    assign accept_c = st_r.state == S_IDLE && instr_done_in &&
        !st_r.nmi_blk && (win_ok || st_r.brk_pend);
    assign req_wr = reg_wr_in &&
        (reg_addr_in == REG_REQH || reg_addr_in == REG_REQL);

    always_comb begin
        st_nxt = st_r;
        st_nxt.mem_wr = 1'b0;
        st_nxt.mem_rd = 1'b0;
        st_nxt.pc_load = 1'b0;
        st_nxt.ack = 1'b0;
        st_nxt.rdata = 8'h00;
        if (reg_wr_in) begin
            if (reg_addr_in == REG_ENH) begin
                st_nxt.en[15:8] = reg_wdata_in;
            end else if (reg_addr_in == REG_ENL) begin
                st_nxt.en[7:0] = {reg_wdata_in[7:1], 1'b0};
            end else if (reg_addr_in == REG_REQH) begin
                st_nxt.req[15:8] = reg_wdata_in;
            end else if (reg_addr_in == REG_REQL) begin
                st_nxt.req[7:0] = {reg_wdata_in[7:1], 1'b0};
            end else if (reg_addr_in == REG_SHR) begin
                st_nxt.shr = reg_wdata_in[NSHR-1:0];
            end else if (reg_addr_in == REG_PSW) begin
                st_nxt.processor_status_word = reg_wdata_in;
            end else if (reg_addr_in == REG_SP) begin
                st_nxt.sp = reg_wdata_in;
            end
        end
        if (reg_rd_in) begin
            if (reg_addr_in == REG_ENH) begin
                st_nxt.rdata = st_r.en[15:8];
            end else if (reg_addr_in == REG_ENL) begin
                st_nxt.rdata = st_r.en[7:0];
            end else if (reg_addr_in == REG_REQH) begin
                st_nxt.rdata = st_r.req[15:8];
            end else if (reg_addr_in == REG_REQL) begin
                st_nxt.rdata = st_r.req[7:0];
            end else if (reg_addr_in == REG_SHR) begin
                st_nxt.rdata = {{(8-NSHR){1'b0}}, st_r.shr};
            end else if (reg_addr_in == REG_PSW) begin
                st_nxt.rdata = st_r.processor_status_word;
            end else if (reg_addr_in == REG_SP) begin
                st_nxt.rdata = st_r.sp;
            end
        end
        if (irq_enable_op_in) begin
            st_nxt.processor_status_word[PSW_I_BIT] = 1'b1;
        end
        case (st_r.state)
            S_IDLE: begin
                if (accept_c) begin
                    st_nxt.state = S_ACC0;
                    st_nxt.ack = 1'b1;
                    st_nxt.src = win;
                    st_nxt.break_op = brk_sel;
                    st_nxt.ret_pc = ret_pc_in;
                    st_nxt.saved_psw = st_r.processor_status_word;
                    if (brk_sel) begin
                        st_nxt.brk_pend = 1'b0;
                        st_nxt.nmi_blk = 1'b1;
                        st_nxt.processor_status_word[PSW_B_BIT] = 1'b1;
                        st_nxt.saved_psw[PSW_B_BIT] = 1'b1;
                        st_nxt.vec = TCALL0_P;
                    end else begin
                        st_nxt.processor_status_word[PSW_I_BIT] = 1'b0;
                        st_nxt.req[15-int'(win)] = 1'b0;
                        st_nxt.vec = VEC_BASE_P + {11'h000, win, 1'b0};
                    end
                end else if (irq_return_op_in) begin
                    st_nxt.state = S_RET0;
                    st_nxt.mem_rd = 1'b1;
                    st_nxt.sp = st_r.sp + 8'h01;
                    st_nxt.mem_addr = {STACK_PAGE, st_r.sp + 8'h01};
                end
            end
            S_ACC0: begin
                st_nxt.state = S_ACC1;
                st_nxt.mem_wr = 1'b1;
                st_nxt.mem_addr = {STACK_PAGE, st_r.sp};
                st_nxt.mem_wdata = st_r.ret_pc[15:8];
                st_nxt.sp = st_r.sp - 8'h01;
            end
            S_ACC1: begin
                st_nxt.state = S_ACC2;
                st_nxt.mem_wr = 1'b1;
                st_nxt.mem_addr = {STACK_PAGE, st_r.sp};
                st_nxt.mem_wdata = st_r.ret_pc[7:0];
                st_nxt.sp = st_r.sp - 8'h01;
            end
            S_ACC2: begin
                // Only the return address and status word are stacked.
                st_nxt.state = S_ACC3;
                st_nxt.mem_wr = 1'b1;
                st_nxt.mem_addr = {STACK_PAGE, st_r.sp};
                st_nxt.mem_wdata = st_r.saved_psw;
                st_nxt.sp = st_r.sp - 8'h01;
            end
            S_ACC3: begin
                st_nxt.state = S_ACC4;
                st_nxt.mem_rd = 1'b1;
                st_nxt.mem_addr = st_r.vec;
            end
            S_ACC4: begin
                st_nxt.state = S_ACC5;
                st_nxt.mem_rd = 1'b1;
                st_nxt.mem_addr = st_r.vec + 16'h0001;
            end
            S_ACC5: begin
                st_nxt.state = S_ACC6;
                st_nxt.pc[7:0] = mem_rdata_in;
            end
            S_ACC6: begin
                st_nxt.state = S_ACC7;
                st_nxt.pc[15:8] = mem_rdata_in;
                st_nxt.pc_load = 1'b1;
            end
            S_ACC7: begin
                st_nxt.state = S_IDLE;
            end
            S_RET0: begin
                st_nxt.state = S_RET1;
                st_nxt.mem_rd = 1'b1;
                st_nxt.sp = st_r.sp + 8'h01;
                st_nxt.mem_addr = {STACK_PAGE, st_r.sp + 8'h01};
            end
            S_RET1: begin
                st_nxt.state = S_RET2;
                st_nxt.processor_status_word = mem_rdata_in;
                st_nxt.mem_rd = 1'b1;
                st_nxt.sp = st_r.sp + 8'h01;
                st_nxt.mem_addr = {STACK_PAGE, st_r.sp + 8'h01};
            end
            S_RET2: begin
                st_nxt.state = S_RET3;
                st_nxt.pc[7:0] = mem_rdata_in;
            end
            S_RET3: begin
                st_nxt.state = S_IDLE;
                st_nxt.pc[15:8] = mem_rdata_in;
                st_nxt.pc_load = 1'b1;
                st_nxt.nmi_blk = 1'b0;
            end
            default: begin
                st_nxt.state = S_IDLE;
            end
        endcase
        // New events win over any clear in the same cycle.
        st_nxt.req = st_nxt.req | set_vec;
        st_nxt.shr = st_nxt.shr | shared_event_in;
        if (break_op_in) begin
            st_nxt.brk_pend = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            st_r <= '0;
            st_r.state <= S_IDLE;
            st_r.processor_status_word <= PSW_RST;
            st_r.saved_psw <= PSW_RST;
            st_r.sp <= SP_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign reg_rdata_out = st_r.rdata;
    assign busy_out = st_r.state != S_IDLE;
    assign ack_out = st_r.ack;
    assign ack_src_out = st_r.src;
    assign pc_out = st_r.pc;
    assign pc_load_out = st_r.pc_load;
    assign mem_wr_out = st_r.mem_wr;
    assign mem_rd_out = st_r.mem_rd;
    assign mem_addr_out = st_r.mem_addr;
    assign mem_wdata_out = st_r.mem_wdata;
    assign psw_out = st_r.processor_status_word;
    assign sp_out = st_r.sp;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    req_hold_a: assert property (
        !req_wr && !accept_c |=> (st_r.req & $past(st_r.req)) ==
            $past(st_r.req))
        else $error("request flag lost without acceptance");
    acc_len_a: assert property (
        st_r.state == S_ACC0 |-> ##7 st_r.state == S_ACC7 ##1
            st_r.state == S_IDLE)
        else $error("acceptance sequence not eight cycles");
    mask_clear_a: assert property (
        accept_c && !brk_sel && !irq_enable_op_in |=>
            !st_r.processor_status_word[PSW_I_BIT])
        else $error("master enable not cleared on acceptance");
    src_clear_a: assert property (
        accept_c && !brk_sel && !set_vec[15-int'(win)] |=>
            !st_r.req[15-int'(st_r.src)])
        else $error("accepted request flag not cleared");
    push_three_a: assert property (
        st_r.state == S_ACC0 |-> ##3 st_r.sp == $past(st_r.sp, 3) - 8'h03)
        else $error("stack pointer not decremented three times");
    vec_load_a: assert property (
        st_r.state == S_ACC4 |-> ##3 (pc_load_out &&
            pc_out == {$past(mem_rdata_in), $past(mem_rdata_in, 2)}))
        else $error("entry address not loaded from vector");
    iflag_gate_a: assert property (
        accept_c && !brk_sel |-> st_r.processor_status_word[PSW_I_BIT])
        else $error("maskable accepted with master enable low");
    enable_gate_a: assert property (
        accept_c && !brk_sel |-> st_r.en[15-int'(win)])
        else $error("disabled source accepted");
    brk_flag_a: assert property (
        accept_c && brk_sel |=> st_r.processor_status_word[PSW_B_BIT] &&
            st_r.vec == TCALL0_P)
        else $error("break flag or vector wrong");
    prio_pick_a: assert property (
        accept_c && !brk_sel |->
            (elig & ~(16'hFFFF >> win)) == 16'h0000)
        else $error("lower priority source picked first");
    brk_wait_a: assert property (
        accept_c && win_ok && st_r.brk_pend |=>
            st_r.brk_pend && !st_r.break_op)
        else $error("break taken ahead of a maskable source");
    nmi_block_a: assert property (
        st_r.nmi_blk && instr_done_in |=> !ack_out)
        else $error("acceptance while blocked after break");
    push_first_a: assert property (
        st_r.state == S_ACC0 |=> mem_wr_out &&
            mem_addr_out == {STACK_PAGE, $past(st_r.sp)} &&
            mem_wdata_out == st_r.ret_pc[15:8])
        else $error("return address high byte not pushed first");
    ret_end_a: assert property (
        st_r.state == S_RET3 |=> !busy_out && pc_load_out &&
            !st_r.nmi_blk)
        else $error("return sequence did not end the service");
    psw_pop_a: assert property (
        st_r.state == S_RET1 |=> psw_out == $past(mem_rdata_in))
        else $error("status word not restored from stack");
    // Shared flags may only drop through a software write.
    shr_hold_a: assert property (
        !(reg_wr_in && reg_addr_in == REG_SHR) |=>
            (st_r.shr & $past(st_r.shr)) == $past(st_r.shr))
        else $error("shared flag lost without a write");
    shr_set_a: assert property (
        shared_event_in != '0 |=>
            (st_r.shr & $past(shared_event_in)) == $past(shared_event_in))
        else $error("shared source event not recorded");
    ser0_req_a: assert property (
        shared_event_in[SHR_U0TX] || shared_event_in[SHR_U0RX] |=>
            st_r.req[15 - int'(SRC_UART0)])
        else $error("first serial channel request not raised");
    ser1_req_a: assert property (
        shared_event_in[SHR_U1TX] || shared_event_in[SHR_U1RX] |=>
            st_r.req[15 - int'(SRC_UART1)])
        else $error("second serial channel request not raised");
endmodule : ias_sequencer

//--- testbench/ias_core_model.sv
`timescale 1ns/1ps
// Memory side of the core: keeps pushed bytes and serves vector bytes.
module ias_core_model (
    input wire logic sys_clk_in,
    input wire logic reset_n_in,
    input wire logic mem_wr_in,
    input wire logic mem_rd_in,
    input wire logic [15:0] mem_addr_in,
    input wire logic [7:0] mem_wdata_in,
    output logic [7:0] mem_rdata_out
);
    logic [7:0] mem_r [logic [15:0]];

    always @(posedge sys_clk_in) begin
        if (mem_wr_in) begin
            mem_r[mem_addr_in] = mem_wdata_in;
        end
    end

    // Unwritten bytes read as the low address byte plus 0x11; outside a
    // read answer the data toggle so a stale value never passes.
    always @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mem_rdata_out <= 8'h00;
        end else if (mem_rd_in) begin
            mem_rdata_out <= mem_r.exists(mem_addr_in) ? mem_r[mem_addr_in]
                : mem_addr_in[7:0] + 8'h11;
        end else begin
            mem_rdata_out <= ~mem_rdata_out;
        end
    end
endmodule : ias_core_model

//--- testbench/interrupt_accept_sequencer_bench.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
    num_errors++; $display("mismatch %s expected %h seen %h", n, e, g); \
    end end
module interrupt_accept_sequencer_bench import ias_pkg::*;;
    logic sys_clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [14:0] src_ev = '0;
    logic [5:0] sh_ev = '0;
    logic [3:0] ctl = 4'h0;
    logic [15:0] ret_pc = 16'h0000;
    logic [7:0] rdata, mem_wdata_out, mem_rdata, psw_out, sp_out;
    logic busy_out, ack_out, pc_load_out, mem_wr_out, mem_rd_out;
    logic [3:0] ack_src_out;
    logic [15:0] pc_out, mem_addr_out;
    int num_errors = 0;
    int check_count = 0;
    logic [31:0] rng = 32'hef7a_7571;
    logic [15:0] m_en, m_req;
    logic [7:0] m_psw, m_sp;
    logic [15:0] pc_q[$];
    logic [7:0] ps_q[$];

    always #50 sys_clk_in = ~sys_clk_in;

    ias_sequencer dut_u (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
        .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(rdata),
        .src_event_in(src_ev), .shared_event_in(sh_ev),
        .instr_done_in(ctl[0]), .break_op_in(ctl[1]),
        .irq_enable_op_in(ctl[2]), .irq_return_op_in(ctl[3]),
        .ret_pc_in(ret_pc), .busy_out(busy_out), .ack_out(ack_out),
        .ack_src_out(ack_src_out), .pc_out(pc_out),
        .pc_load_out(pc_load_out), .mem_wr_out(mem_wr_out),
        .mem_rd_out(mem_rd_out), .mem_addr_out(mem_addr_out),
        .mem_wdata_out(mem_wdata_out), .mem_rdata_in(mem_rdata),
        .psw_out(psw_out), .sp_out(sp_out)
    );

    ias_core_model core_u (
        .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
        .mem_wr_in(mem_wr_out), .mem_rd_in(mem_rd_out),
        .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out),
        .mem_rdata_out(mem_rdata)
    );

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    function automatic int win();
        for (int i = 0; i < NSRC; i++) begin
            if (m_req[15 - i] && m_en[15 - i]) begin
                return i;
            end
        end
        return -1;
    endfunction : win

    task automatic print_verdict();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : print_verdict

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_in);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd <= 1'b0;
        @(negedge sys_clk_in);
        d = rdata;
    endtask : rd

    task automatic pulse(input logic [3:0] c, input logic [14:0] e = '0,
                         input logic [5:0] s = '0);
        @(posedge sys_clk_in);
        ctl <= c;
        src_ev <= e;
        sh_ev <= s;
        @(posedge sys_clk_in);
        ctl <= 4'h0;
        src_ev <= '0;
        sh_ev <= '0;
    endtask : pulse

    task automatic chk_req();
        logic [7:0] h, l;
        rd(REG_REQH, h);
        rd(REG_REQL, l);
        `CHK("request flags", m_req, {h, l})
    endtask : chk_req

    task automatic none();
        pulse(4'b0001);
        repeat (2) begin
            @(negedge sys_clk_in);
            `CHK("no acceptance", 2'b00, {ack_out, busy_out})
        end
    endtask : none

    task automatic acc(input logic [3:0] s, input logic [15:0] v,
                       input logic b);
        logic [15:0] pc;
        logic [7:0] sp0, ps;
        logic [24:0] wr_g;
        logic [16:0] rd_g;
        logic [6:0] ac_g;
        rng = xs(rng);
        pc = rng[15:0];
        sp0 = m_sp;
        ps = m_psw | {3'b000, b, 4'h0};
        @(posedge sys_clk_in);
        ret_pc <= pc;
        pulse(4'b0001);
        @(negedge sys_clk_in);
        ac_g = {ack_out, busy_out, psw_out[2], ack_src_out};
        `CHK("accept", {2'b11, m_psw[2] & b, s}, ac_g)
        @(negedge sys_clk_in);
        wr_g = {mem_wr_out, mem_addr_out, mem_wdata_out};
        `CHK("push high", {1'b1, 8'h01, sp0, pc[15:8]}, wr_g)
        @(negedge sys_clk_in);
        wr_g = {mem_wr_out, mem_addr_out, mem_wdata_out};
        `CHK("push low", {1'b1, 8'h01, sp0 - 8'h01, pc[7:0]}, wr_g)
        @(negedge sys_clk_in);
        wr_g = {mem_wr_out, mem_addr_out, mem_wdata_out};
        `CHK("push status", {1'b1, 8'h01, sp0 - 8'h02, ps}, wr_g)
        @(negedge sys_clk_in);
        rd_g = {mem_rd_out, mem_addr_out};
        `CHK("vector low", {1'b1, v}, rd_g)
        @(negedge sys_clk_in);
        rd_g = {mem_rd_out, mem_addr_out};
        `CHK("vector high", {1'b1, v + 16'h0001}, rd_g)
        @(negedge sys_clk_in);
        `CHK("entry wait", 2'b01, {pc_load_out, busy_out})
        @(negedge sys_clk_in);
        rd_g = {pc_load_out, pc_out};
        `CHK("entry", {1'b1, v[7:0] + 8'h12, v[7:0] + 8'h11}, rd_g)
        @(negedge sys_clk_in);
        `CHK("accept end", {1'b0, sp0 - 8'h03}, {busy_out, sp_out})
        m_sp = sp0 - 8'h03;
        m_psw[2] = m_psw[2] & b;
        m_psw[4] = m_psw[4] | b;
        pc_q.push_back(pc);
        ps_q.push_back(ps);
        if (!b) begin
            m_req[15 - s] = 1'b0;
        end
    endtask : acc

    task automatic ret();
        logic [15:0] pc;
        logic [7:0] ps, sp0;
        logic [16:0] rd_g;
        pc = pc_q.pop_back();
        ps = ps_q.pop_back();
        sp0 = m_sp;
        pulse(4'b1000);
        @(negedge sys_clk_in);
        rd_g = {mem_rd_out, mem_addr_out};
        `CHK("pop status", {1'b1, 8'h01, sp0 + 8'h01}, rd_g)
        repeat (4) @(negedge sys_clk_in);
        `CHK("return pc", {1'b1, pc}, {pc_load_out, pc_out})
        `CHK("return psw", {ps, sp0 + 8'h03}, {psw_out, sp_out})
        @(negedge sys_clk_in);
        `CHK("return end", 2'b00, {busy_out, pc_load_out})
        m_sp = sp0 + 8'h03;
        m_psw = ps;
    endtask : ret

    initial begin
        repeat (100000) @(posedge sys_clk_in);
        num_errors++;
        print_verdict();
    end

    initial begin
        logic [7:0] h;
        logic [14:0] ev;
        int w;
        m_en = 16'h0000;
        m_req = 16'h0000;
        m_psw = 8'h00;
        m_sp = 8'hFF;
        repeat (8) @(posedge sys_clk_in);
        reset_n_in <= 1'b1;
        for (int a = 0; a < 8; a++) begin
            rd(a[7:0], h);
            `CHK("reset value", (a == 6) ? 8'hFF : 8'h00, h)
        end
        for (int b = 0; b < NSHR; b++) begin
            pulse(4'h0, '0, 6'b000001 << b);
            w = (b < 2) ? SRC_WDTWT : (b < 4) ? SRC_UART0 : SRC_UART1;
            m_req[15 - w] = 1'b1;
            chk_req();
            repeat (2) begin
                rd(REG_SHR, h);
                `CHK("shared flag", 8'h01 << b, h)
            end
            wr(REG_SHR, 8'h00);
            wr(REG_REQH, 8'h00);
            wr(REG_REQL, 8'h00);
            m_req = 16'h0000;
            rd(REG_SHR, h);
            `CHK("shared cleared", 8'h00, h)
        end
        for (int it = 0; it < 8; it++) begin
            rng = xs(rng);
            m_en = rng[15:0] & 16'hFFFE;
            wr(REG_ENH, rng[15:8]);
            wr(REG_ENL, rng[7:0]);
            ev = rng[30:16];
            pulse(4'h0, ev);
            for (int i = 0; i < NSRC; i++) begin
                m_req[15 - i] = m_req[15 - i] | ev[i];
            end
            chk_req();
            pulse(4'b0100);
            m_psw[2] = 1'b1;
            @(negedge sys_clk_in);
            `CHK("master enable", 1'b1, psw_out[2])
            w = win();
            if (w < 0) begin
                none();
            end else begin
                acc(w[3:0], VEC_BASE + 16'(2 * w), 1'b0);
                chk_req();
                none();
                pulse(4'b0100);
                m_psw[2] = 1'b1;
                w = win();
                if (w >= 0) begin
                    acc(w[3:0], VEC_BASE + 16'(2 * w), 1'b0);
                    ret();
                end
                ret();
            end
            wr(REG_REQH, 8'h00);
            wr(REG_REQL, 8'h00);
            m_req = 16'h0000;
        end
        wr(REG_ENH, 8'hFF);
        wr(REG_ENL, 8'hFF);
        m_en = 16'hFFFE;
        pulse(4'b0110, 15'h0080);
        m_req[8] = 1'b1;
        m_psw[2] = 1'b1;
        acc(4'd7, VEC_BASE + 16'h000E, 1'b0);
        ret();
        acc(4'd0, TCALL0_VEC, 1'b1);
        pulse(4'b0100, 15'h0001);
        m_psw[2] = 1'b1;
        m_req[15] = 1'b1;
        none();
        ret();
        acc(4'd0, VEC_BASE, 1'b0);
        ret();
        print_verdict();
    end
endmodule : interrupt_accept_sequencer_bench
